// File: rtl/gpl_pkg.sv
package gpl_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int GPL_NUM_PORTS   = 11;
	localparam int GPL_PORT_W      = 8;
	localparam int GPL_NUM_LINES   = GPL_NUM_PORTS * GPL_PORT_W;
	localparam int GPL_NUM_IO      = 87;
	localparam int GPL_GROUP_W     = 4;
	localparam int GPL_NUM_GROUPS  = GPL_NUM_LINES / GPL_GROUP_W;
	localparam int GPL_IN_ONLY_BIT = 8 * GPL_PORT_W + 5;
	localparam int GPL_P1_BASE     = 1 * GPL_PORT_W;
	localparam int GPL_OD_A_BIT    = 7 * GPL_PORT_W + 0;
	localparam int GPL_OD_B_BIT    = 7 * GPL_PORT_W + 1;
	localparam int GPL_ADDR_W      = 4;
	localparam int GPL_NUM_CS      = 4;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [GPL_NUM_LINES-1:0]  GPL_DIR_RST  = '0;
	localparam logic [GPL_NUM_LINES-1:0]  GPL_LAT_RST  = '0;
	localparam logic [GPL_NUM_GROUPS-1:0] GPL_PU_RST   = '0;
	localparam logic [GPL_NUM_CS-1:0]     GPL_CS_RST   = '0;

	// pull-up groups that lose their pull-up in bus modes: ports 0-3, p4 low, port 5
	localparam logic [GPL_NUM_GROUPS-1:0] GPL_BUS_PU_GRP = 22'h000dff;

	// register write/read selectors
	typedef enum logic [GPL_ADDR_W-1:0] {
		GPL_SEL_DATA = 4'h0,
		GPL_SEL_DIR  = 4'h1,
		GPL_SEL_PU   = 4'h2,
		GPL_SEL_CTRL = 4'h3
	} gpl_sel_t;

	// processor modes
	typedef enum logic [2:0] {
		GPL_MODE_SINGLE = 3'b001,
		GPL_MODE_MEMEXP = 3'b010,
		GPL_MODE_MICRO  = 3'b100
	} gpl_mode_t;

	// software access request
	typedef struct packed {
		logic                  wr;
		logic [3:0]            port;
		gpl_sel_t              sel;
		logic [GPL_PORT_W-1:0] wdata;
	} gpl_req_t;

	// per-line pin drive
	typedef struct packed {
		logic [GPL_NUM_LINES-1:0] out;
		logic [GPL_NUM_LINES-1:0] oe;
		logic [GPL_NUM_LINES-1:0] pu;
	} gpl_pin_t;

endpackage : gpl_pkg

// File: rtl/gpl_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ********************************************************************
// two-stage synchroniser for pin levels
// ********************************************************************
module gpl_sync
	import gpl_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	input  wire logic [W-1:0] i_async,
	output var  logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpl_sync_st_t;

	gpl_sync_st_t st_q;
	gpl_sync_st_t st_d;

	// first stage feeds only the second
	always_comb begin
		st_d    = st_q;
		st_d.s1 = i_async;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_sync = st_q.s2;

endmodule : gpl_sync

`default_nettype wire

// File: rtl/gpl_port.sv
`timescale 1ns/100ps
`default_nettype none


module gpl_port
	import gpl_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_reset_n,
	input  wire gpl_req_t                  i_req,
	input  wire logic                      i_req_valid,
	input  wire logic                      i_processor_mode_pin,
	input  wire logic [GPL_NUM_LINES-1:0]  i_pin,
	input  wire logic [GPL_NUM_LINES-1:0]  i_periph_oe,
	input  wire logic [GPL_NUM_LINES-1:0]  i_periph_out,
	input  wire logic [GPL_NUM_LINES-1:0]  i_bus_pin_mask,
	input  wire logic [GPL_NUM_LINES-1:0]  i_cs_line_mask,
	input  wire logic                      i_bus_clk,
	input  wire logic [GPL_NUM_LINES-1:0]  i_bus_clk_mask,
	output var  logic [GPL_PORT_W-1:0]     o_rdata,
	output var  logic                      o_rvalid,
	output var  logic [GPL_NUM_LINES-1:0]  o_pin_out,
	output var  logic [GPL_NUM_LINES-1:0]  o_pin_oe,
	output var  logic [GPL_NUM_LINES-1:0]  o_pin_pullup,
	output var  gpl_mode_t                 o_mode,
	output var  logic [GPL_NUM_CS-1:0]     o_chip_select_ctrl,
	output var  logic                      o_bus_clock_out_disable,
	output var  logic                      o_port1_latch_read_sel
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [GPL_NUM_LINES-1:0]  port_direction_reg;
		logic [GPL_NUM_LINES-1:0]  port_data_reg;
		logic [GPL_NUM_GROUPS-1:0] pullup_ctrl;
		logic                      port1_latch_read_sel;
		logic [GPL_NUM_CS-1:0]     chip_select_ctrl;
		logic                      bus_clock_out_disable;
		gpl_mode_t                 mode;
		logic                      mode_captured;
		logic [1:0]                strap_wait;
		logic [GPL_PORT_W-1:0]     rdata;
		logic                      rvalid;
		gpl_pin_t                  pin;
	} gpl_st_t;

	gpl_st_t                  st_q;
	gpl_st_t                  st_d;
	logic [GPL_NUM_LINES-1:0] pin_s;
	logic                     mode_pin_s;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// pins and the mode strap share one synchroniser
	gpl_sync #(
		.W (GPL_NUM_LINES + 1)
	) u_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_processor_mode_pin, i_pin}),
		.o_sync    ({mode_pin_s, pin_s})
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// used by the read path for data and direction bytes
	// byte select for one port
	function automatic logic [GPL_PORT_W-1:0] gpl_byte(
		input logic [GPL_NUM_LINES-1:0] v,
		input logic [3:0]               p
	);
		gpl_byte = v[p*GPL_PORT_W +: GPL_PORT_W];
	endfunction : gpl_byte

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		// scratch values for this cycle
		logic                     bus_mode;
		logic [GPL_NUM_LINES-1:0] lock;
		logic [GPL_NUM_LINES-1:0] dir_eff;
		logic [GPL_NUM_LINES-1:0] read_v;
		logic [GPL_NUM_LINES-1:0] drv_val;
		logic [GPL_NUM_LINES-1:0] pu_line;
		logic [GPL_NUM_GROUPS-1:0] pu_grp;
		logic [GPL_PORT_W-1:0]    rb;
		int                       base;
		bus_mode = 1'b0;
		lock     = '0;
		dir_eff  = '0;
		read_v   = '0;
		drv_val  = '0;
		pu_line  = '0;
		pu_grp   = '0;
		rb       = '0;
		base     = 0;
		st_d     = st_q;
		st_d.rvalid = 1'b0;

		// ************************************************************
		// mode strap
		// ************************************************************
		// the synchroniser is cleared by reset, so wait until both
		// stages hold the real pin level before taking the strap
		// mode strap
		if (!st_q.mode_captured) begin
			if (st_q.strap_wait == 2'h2) begin
				st_d.mode_captured = 1'b1;
				st_d.mode          = mode_pin_s ? GPL_MODE_MICRO : GPL_MODE_SINGLE;
			end else begin
				st_d.strap_wait = st_q.strap_wait + 2'h1;
			end
		end
		// expansion and microprocessor modes both count as bus modes
		bus_mode = (st_q.mode != GPL_MODE_SINGLE);

		// ************************************************************
		// direction write lock
		// ************************************************************
		// bus pin lock
		lock = bus_mode ? i_bus_pin_mask : '0;
		// chip-select lines share one mask, so any disabled select
		// frees all of them; finer control needs a mask per select
		// chip select release
		for (int c = 0; c < GPL_NUM_CS; c++) begin
			if (!st_q.chip_select_ctrl[c]) begin
				lock = lock & ~i_cs_line_mask;
			end
		end

		// ************************************************************
		// software access
		// ************************************************************
		// ports 11 and above are ignored and get no answer
		base = int'(i_req.port) * GPL_PORT_W;
		if (i_req_valid && (i_req.port < 4'(GPL_NUM_PORTS))) begin
			if (i_req.wr) begin
				// one selector per request
				case (i_req.sel)
					GPL_SEL_DATA: begin
						st_d.port_data_reg[base +: GPL_PORT_W] = i_req.wdata;
					end
					GPL_SEL_DIR: begin
						for (int b = 0; b < GPL_PORT_W; b++) begin
							if (!lock[base+b]) begin
								st_d.port_direction_reg[base+b] = i_req.wdata[b];
							end
						end
						st_d.port_direction_reg[GPL_IN_ONLY_BIT] = 1'b0;
					end
					GPL_SEL_PU: begin
						st_d.pullup_ctrl[i_req.port*2 +: 2] = i_req.wdata[1:0];
					end
					GPL_SEL_CTRL: begin
						// a software mode choice outranks a strap not yet taken
						st_d.mode_captured         = 1'b1;
						st_d.port1_latch_read_sel  = i_req.wdata[0];
						st_d.chip_select_ctrl      = i_req.wdata[4:1];
						st_d.bus_clock_out_disable = i_req.wdata[5];
						if (i_req.wdata[7:6] == 2'b01) begin
							st_d.mode = GPL_MODE_MEMEXP;
						end else if (i_req.wdata[7:6] == 2'b11) begin
							st_d.mode = GPL_MODE_MICRO;
						end else if (i_req.wdata[7:6] == 2'b00) begin
							st_d.mode = GPL_MODE_SINGLE;
						end
					end
					default: begin
					end
				endcase
			end else begin
				// read-back assembly for the addressed port
				// read source
				read_v = (st_q.port_direction_reg & st_q.port_data_reg)
				       | (~st_q.port_direction_reg & pin_s);
				read_v[GPL_IN_ONLY_BIT] = pin_s[GPL_IN_ONLY_BIT];
				if (st_q.port1_latch_read_sel) begin
					read_v[GPL_P1_BASE +: GPL_PORT_W] =
						st_q.port_data_reg[GPL_P1_BASE +: GPL_PORT_W];
				end
				case (i_req.sel)
					GPL_SEL_DATA: rb = gpl_byte(read_v, i_req.port);
					GPL_SEL_DIR:  rb = gpl_byte(st_q.port_direction_reg, i_req.port);
					GPL_SEL_PU:   rb = {6'h00, st_q.pullup_ctrl[i_req.port*2 +: 2]};
					GPL_SEL_CTRL: rb = {(st_q.mode == GPL_MODE_MICRO),
					                    (st_q.mode != GPL_MODE_SINGLE),
					                    st_q.bus_clock_out_disable,
					                    st_q.chip_select_ctrl,
					                    st_q.port1_latch_read_sel};
					default:      rb = 8'h00;
				endcase
				st_d.rdata  = rb;
				st_d.rvalid = 1'b1;
			end
		end

		// ************************************************************
		// pin drive
		// ************************************************************
		// a peripheral output overrides the direction bit
		// pin drive
		dir_eff = st_q.port_direction_reg | i_periph_oe;
		drv_val = (i_periph_oe & i_periph_out) | (~i_periph_oe & st_q.port_data_reg);
		// in bus modes the bus clock owns its pin unless its output is disabled
		// bus clock pin
		if (bus_mode && !st_q.bus_clock_out_disable) begin
			dir_eff = dir_eff | i_bus_clk_mask;
			drv_val = (drv_val & ~i_bus_clk_mask) | ({GPL_NUM_LINES{i_bus_clk}} & i_bus_clk_mask);
		end else if (bus_mode) begin
			dir_eff = dir_eff & ~i_bus_clk_mask;
		end
		// interrupt pin is never driven, whatever the request
		// input only line
		dir_eff[GPL_IN_ONLY_BIT] = 1'b0;
		// open-drain lines only sink; a high level releases the pin
		// open drain lines
		if (drv_val[GPL_OD_A_BIT]) begin
			dir_eff[GPL_OD_A_BIT] = 1'b0;
		end
		if (drv_val[GPL_OD_B_BIT]) begin
			dir_eff[GPL_OD_B_BIT] = 1'b0;
		end
		// pin outputs lag the registers by one cycle
		st_d.pin.out = drv_val;
		st_d.pin.oe  = dir_eff;

		// ************************************************************
		// pull-ups
		// ************************************************************
		// pull-ups
		pu_grp = bus_mode ? (st_q.pullup_ctrl & ~GPL_BUS_PU_GRP) : st_q.pullup_ctrl;
		// one enable bit fans out to its four lines
		for (int g = 0; g < GPL_NUM_GROUPS; g++) begin
			pu_line[g*GPL_GROUP_W +: GPL_GROUP_W] = {GPL_GROUP_W{pu_grp[g]}};
		end
		// output direction or any drive on the pin disconnects the pull-up
		pu_line = pu_line & ~st_q.port_direction_reg & ~i_periph_oe & ~dir_eff;
		pu_line[GPL_IN_ONLY_BIT] = 1'b0;
		st_d.pin.pu = pu_line;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// reset to input
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			// all lines input, single chip mode until the strap is taken
			st_q      <= '0;
			st_q.mode <= GPL_MODE_SINGLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// outputs straight from state flops
	assign o_rdata                 = st_q.rdata;
	assign o_rvalid                = st_q.rvalid;
	assign o_pin_out               = st_q.pin.out;
	assign o_pin_oe                = st_q.pin.oe;
	assign o_pin_pullup            = st_q.pin.pu;
	assign o_mode                  = st_q.mode;
	assign o_chip_select_ctrl      = st_q.chip_select_ctrl;
	assign o_bus_clock_out_disable = st_q.bus_clock_out_disable;
	assign o_port1_latch_read_sel  = st_q.port1_latch_read_sel;

endmodule : gpl_port

`default_nettype wire

// File: tb/gpl_chk.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// port behaviour checker
// ****************************************************************
module gpl_chk
	import gpl_pkg::*;
(
	input wire logic                     i_clk,
	input wire logic                     i_reset_n,
	input wire gpl_req_t                 i_req,
	input wire logic                     i_req_valid,
	input wire logic [GPL_NUM_LINES-1:0] i_periph_oe,
	input wire logic                     o_rvalid,
	input wire logic [GPL_NUM_LINES-1:0] o_pin_out,
	input wire logic [GPL_NUM_LINES-1:0] o_pin_oe,
	input wire logic [GPL_NUM_LINES-1:0] o_pin_pullup,
	input wire gpl_mode_t                o_mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// an accepted read request
	sequence s_rd;
		i_req_valid && !i_req.wr && (i_req.port < 4'hb);
	endsequence
	property p_read;
		s_rd |=> o_rvalid;
	endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_quiet;
		!(i_req_valid && !i_req.wr && (i_req.port < 4'hb)) |=> !o_rvalid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("answer without read");
	property p_rst;
		$rose(i_reset_n) |-> (o_pin_oe == '0) && (o_pin_pullup == '0);
	endproperty
	a_rst: assert property (p_rst) else $error("line not input after reset");
	property p_in_only;
		!o_pin_oe[GPL_IN_ONLY_BIT] && !o_pin_pullup[GPL_IN_ONLY_BIT];
	endproperty
	a_in_only: assert property (p_in_only) else $error("input-only line driven");
	property p_od_a;
		o_pin_oe[GPL_OD_A_BIT] |-> !o_pin_out[GPL_OD_A_BIT];
	endproperty
	a_od_a: assert property (p_od_a) else $error("open drain a drives high");
	property p_od_b;
		o_pin_oe[GPL_OD_B_BIT] |-> !o_pin_out[GPL_OD_B_BIT];
	endproperty
	a_od_b: assert property (p_od_b) else $error("open drain b drives high");
	property p_periph;
		i_periph_oe[3] [*3] |-> o_pin_oe[3];
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral output not driven");
	property p_pu_dir;
		(o_pin_pullup & o_pin_oe) == '0;
	endproperty
	a_pu_dir: assert property (p_pu_dir) else $error("pull-up on output line");
	property p_bus_pu;
		(o_mode != GPL_MODE_SINGLE) && ($past(o_mode) != GPL_MODE_SINGLE)
			|-> (o_pin_pullup[35:0] == '0) && (o_pin_pullup[47:40] == '0);
	endproperty
	a_bus_pu: assert property (p_bus_pu) else $error("pull-up in bus mode");
endmodule : gpl_chk

bind gpl_port gpl_chk u_chk (.i_clk, .i_reset_n, .i_req, .i_req_valid, .i_periph_oe,
	.o_rvalid, .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_mode);

`default_nettype wire

// File: tb/gpl_pins.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// external pin model
// ****************************************************************
module gpl_pins
	import gpl_pkg::*;
(
	input  wire logic        i_clk,
	input  wire gpl_pin_t    i_drv,
	input  wire logic [87:0] i_ext,
	input  wire logic [87:0] i_ext_en,
	output var  logic [87:0] o_level
);
	logic [87:0] flt_q = '0;

	// floating lines toggle so no stale value is read
	always_ff @(posedge i_clk) begin
		flt_q <= ~flt_q;
	end

	// device drive wins, then board, then pull-up
	always_comb begin
		o_level = (i_drv.oe & i_drv.out) | (~i_drv.oe & i_ext_en & i_ext)
			| (~i_drv.oe & ~i_ext_en & (i_drv.pu | flt_q));
	end
endmodule : gpl_pins

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// port testbench
// ****************************************************************
module tb_top
	import gpl_pkg::*;
;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_req_valid = 1'b0;
	gpl_req_t    i_req = '0;
	logic [87:0] ext = {11{8'ha5}};
	logic [87:0] ext_en = '1;
	logic [87:0] periph_oe = '0;
	logic [87:0] bus_mask = '0;
	logic [87:0] cs_mask = '0;
	logic [87:0] bclk_mask = '0;
	logic        strap = 1'b0;
	logic [87:0] pin_lvl, p_out, p_oe, p_pu;
	logic [7:0]  rdata;
	logic        rvalid, bcd, l1s;
	logic [3:0]  csc;
	gpl_mode_t   mode;
	gpl_pin_t    drv;
	int          errors = 0;
	int          checks = 0;
	int          cyc = 0;

	assign drv = '{out: p_out, oe: p_oe, pu: p_pu};

	gpl_port uut (.i_clk, .i_reset_n, .i_req, .i_req_valid, .i_processor_mode_pin(strap),
		.i_pin(pin_lvl), .i_periph_oe(periph_oe), .i_periph_out('0), .i_bus_pin_mask(bus_mask),
		.i_cs_line_mask(cs_mask), .i_bus_clk(1'b0), .i_bus_clk_mask(bclk_mask), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_pin_out(p_out), .o_pin_oe(p_oe), .o_pin_pullup(p_pu),
		.o_mode(mode), .o_chip_select_ctrl(csc), .o_bus_clock_out_disable(bcd),
		.o_port1_latch_read_sel(l1s));
	gpl_pins u_pins (.i_clk, .i_drv(drv), .i_ext(ext), .i_ext_en(ext_en), .o_level(pin_lvl));

	task automatic tally_and_finish;
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string n, input logic [87:0] e, input logic [87:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// one access; for reads d is the expected data
	task automatic xf(input logic w, input int p, input gpl_sel_t s, input logic [7:0] d);
		i_req = '{wr: w, port: 4'(p), sel: s, wdata: d};
		i_req_valid = 1'b1;
		@(posedge i_clk);
		#1;
		i_req_valid = 1'b0;
		if (!w) begin
			chk("rvalid", 88'(p < 11), 88'(rvalid));
			if (p < 11) chk("rdata", 88'(d), 88'(rdata));
		end
		@(posedge i_clk);
		#1;
	endtask : xf

	task automatic tic(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tic

	// clock and cycle ceiling
	initial forever #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish;
		end
	end

	// main sequence
	initial begin
		tic(3);
		i_reset_n = 1'b1;
		tic(4);
		chk("mode", 88'(GPL_MODE_SINGLE), 88'(mode));
		for (int p = 0; p < 11; p++) begin
			xf(1'b0, p, GPL_SEL_DIR, 8'h00);
			xf(1'b1, p, GPL_SEL_DIR, 8'h00);
			xf(1'b0, p, GPL_SEL_DATA, 8'ha5);
		end
		xf(1'b0, 11, GPL_SEL_DATA, 8'h00);
		xf(1'b1, 8, GPL_SEL_DIR, 8'hff);
		xf(1'b0, 8, GPL_SEL_DIR, 8'hdf);
		xf(1'b1, 8, GPL_SEL_DATA, 8'hff);
		ext[GPL_IN_ONLY_BIT] = 1'b0;
		tic(4);
		xf(1'b0, 8, GPL_SEL_DATA, 8'hdf);
		xf(1'b1, 2, GPL_SEL_DATA, 8'h3c);
		xf(1'b0, 2, GPL_SEL_DATA, 8'ha5);
		chk("oe p2", 88'h0, 88'(p_oe[23:16]));
		xf(1'b1, 2, GPL_SEL_DIR, 8'hff);
		xf(1'b0, 2, GPL_SEL_DATA, 8'h3c);
		chk("out p2", 88'h3c, 88'(p_out[23:16]));
		chk("oe p2 out", 88'hff, 88'(p_oe[23:16]));
		xf(1'b1, 1, GPL_SEL_DATA, 8'h5a);
		xf(1'b1, 3, GPL_SEL_CTRL, 8'h01);
		xf(1'b0, 1, GPL_SEL_DATA, 8'h5a);
		xf(1'b1, 3, GPL_SEL_CTRL, 8'h00);
		xf(1'b0, 1, GPL_SEL_DATA, 8'ha5);
		xf(1'b1, 6, GPL_SEL_PU, 8'h01);
		chk("pu p6", 88'h0f, 88'(p_pu[55:48]));
		xf(1'b1, 6, GPL_SEL_DIR, 8'h01);
		chk("pu p6 dir", 88'h0e, 88'(p_pu[55:48]));
		xf(1'b1, 7, GPL_SEL_DATA, 8'h01);
		xf(1'b1, 7, GPL_SEL_DIR, 8'h03);
		chk("od p7", 88'h2, 88'(p_oe[57:56]));
		periph_oe[3] = 1'b1;
		tic(3);
		chk("periph oe", 88'h1, 88'(p_oe[3]));
		periph_oe[3] = 1'b0;
		bus_mask = 88'h10_0000_00ff;
		cs_mask = 88'h10_0000_0000;
		bclk_mask[83] = 1'b1;
		xf(1'b1, 0, GPL_SEL_CTRL, 8'h7e);
		xf(1'b0, 0, GPL_SEL_CTRL, 8'h7e);
		chk("bclk off", 88'h1, 88'(bcd));
		chk("bclk oe off", 88'h0, 88'(p_oe[83]));
		xf(1'b1, 0, GPL_SEL_CTRL, 8'h5e);
		chk("bclk oe on", 88'h1, 88'(p_oe[83]));
		xf(1'b1, 0, GPL_SEL_CTRL, 8'h7e);
		xf(1'b1, 0, GPL_SEL_DIR, 8'hff);
		xf(1'b0, 0, GPL_SEL_DIR, 8'h00);
		xf(1'b1, 4, GPL_SEL_DIR, 8'hff);
		xf(1'b0, 4, GPL_SEL_DIR, 8'hef);
		xf(1'b1, 0, GPL_SEL_CTRL, 8'h7c);
		chk("cs enables", 88'he, 88'(csc));
		xf(1'b1, 4, GPL_SEL_DIR, 8'hff);
		xf(1'b0, 4, GPL_SEL_DIR, 8'hff);
		xf(1'b1, 0, GPL_SEL_PU, 8'h03);
		xf(1'b0, 0, GPL_SEL_PU, 8'h03);
		chk("pu bus", 88'h0, 88'(p_pu[7:0]));
		xf(1'b1, 5, GPL_SEL_PU, 8'h03);
		chk("pu bus p5", 88'h0, 88'(p_pu[47:40]));
		xf(1'b1, 4, GPL_SEL_DIR, 8'h00);
		xf(1'b1, 4, GPL_SEL_PU, 8'h02);
		chk("pu p4 high", 88'hf0, 88'(p_pu[39:32]));
		chk("pu p6 bus", 88'h0e, 88'(p_pu[55:48]));
		// second reset with the strap high selects microprocessor mode
		i_reset_n = 1'b0;
		strap = 1'b1;
		tic(3);
		i_reset_n = 1'b1;
		tic(4);
		chk("mode strap", 88'(GPL_MODE_MICRO), 88'(mode));
		tally_and_finish;
	end
endmodule : tb_top

`default_nettype wire
